// ### core/serial_cmd_port.sv
// host command port with spi and i2c target and memory page manager
//
// Function
// - during a command frame, return status then two data bytes of previous command.
// - select pin high makes the host port an i2c target.
// - in i2c high-speed mode every command frame is exactly three bytes.
// - status byte can be read at any time, even while busy.
// - i2c target never stretches clock and uses 7-bit addresses only.
// - memory has four pages; each word programs once per page.
// - page increment advances counter and invalidates every word of old page.
// - page counter starts at zero, saturates at three, never decrements.
// - on the last page further page increments are refused.
// - customer page written through write command codes 40 to 57 hex.
// - trim page writable only during production test.
// - reads 20 to 37 hex return memory words, 80 to 8e hex return memory status.
// - memory status bit 15 corrected, bits 14:13 page, rest undefined.
// - words 00 and 01 hold the customer identifier, reset zero.
// - config bit 9 sets select polarity, zero active low.
// - config bits 11:10 set spi clock idle level and latch edge.
// - select pin low makes the host port an spi slave.
// - status bit 5 shows busy; no command processed while busy.
// - status bit 1 set when a memory write or page increment is refused.
module serial_cmd_port
   import cmd_port_pkg::*;
#(
   parameter int MEM_WORDS = 24,
   parameter int TRIM_WORDS = 4
) (
   // system
   input wire logic clk,
   input wire logic rst_n,
   // mode and strap pins
   input wire logic if_sel,
   input wire logic prod_test,
   // spi pins, the serial clock is the link clock
   input wire logic spi_sclk,
   input wire logic spi_ss,
   input wire logic spi_mosi,
   output logic spi_miso_out,
   output logic spi_miso_oe_n,
   // i2c pins, data is open drain
   input wire logic i2c_scl,
   input wire logic i2c_sda_in,
   output logic i2c_sda_out,
   output logic i2c_sda_oe_n,
   // cell array flag for the word being read
   input wire logic ecc_corrected,
   // state seen by the rest of the device
   output logic busy,
   output logic [1:0] page_count,
   output logic [2*WORD_W-1:0] customer_id,
   output logic [TRIM_WORDS*WORD_W-1:0] trim_bits
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (MEM_WORDS < 3 || MEM_WORDS > 24) begin : g_bad_mem
      $error("MEM_WORDS must lie between 3 and 24");
   end
   if (TRIM_WORDS < 1 || TRIM_WORDS > 4) begin : g_bad_trim
      $error("TRIM_WORDS must lie between 1 and 4");
   end

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      I2C_IDLE = 3'b000,
      I2C_ADDR = 3'b001,
      I2C_ADDR_ACK = 3'b010,
      I2C_WRITE = 3'b011,
      I2C_WRITE_ACK = 3'b100,
      I2C_READ = 3'b101,
      I2C_READ_ACK = 3'b110
   } i2c_state_t;

   typedef struct packed {
      logic [1:0] sel_sync;
      logic [1:0] prod_sync;
      logic [2:0] scl_sync;
      logic [2:0] sda_sync;
      logic [2:0] frame_sync;
      i2c_state_t i2c_st;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic rw;
      logic ack_ok;
      logic hs_mode;
      logic [1:0] byte_cnt;
      logic [FRAME_BITS-1:0] i2c_frame;
      logic [1:0] rd_idx;
      logic sda_low;
      logic busy;
      logic [7:0] exec_cnt;
      logic [FRAME_BITS-1:0] cmd;
      logic [1:0] page;
      logic [MEM_WORDS-1:0] prog;
      logic [MEM_WORDS-1:0][WORD_W-1:0] mem;
      logic [TRIM_WORDS-1:0][WORD_W-1:0] trim;
      logic data_flag;
      logic [WORD_W-1:0] data;
   } state_t;

   state_t s_reg, s_next;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic in_range(input logic [7:0] c,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (c >= lo) && (c <= hi);
   endfunction : in_range

   function automatic logic [7:0] resp_byte(input logic [1:0] idx,
                                            input logic [23:0] resp);
      case (idx)
         2'h0: resp_byte = resp[23:16];
         2'h1: resp_byte = resp[15:8];
         2'h2: resp_byte = resp[7:0];
         default: resp_byte = 8'h00;
      endcase
   endfunction : resp_byte

   // ----------------------------------------------------------------
   // response word and configuration fields
   // ----------------------------------------------------------------
   logic [7:0] status_byte;
   logic [FRAME_BITS-1:0] resp_word;
   logic [WORD_W-1:0] cfg_word;
   logic [ADDR_W-1:0] i2c_addr;
   logic [1:0] clk_mode;
   logic spi_frame_tgl;
   logic spi_selected;
   logic [FRAME_BITS-1:0] spi_frame;

   // status is built live so it can be read while busy
   always_comb begin
      status_byte = 8'h00;
      status_byte[ST_POWER] = 1'b1;
      status_byte[ST_BUSY] = s_reg.busy;
      status_byte[ST_MODE_LSB +: 2] = MODE_NORMAL;
      status_byte[ST_MEM_ERR] = 1'b0;
      status_byte[ST_DATA_FLAG] = s_reg.data_flag;
   end

   assign resp_word = {status_byte, s_reg.data};
   assign cfg_word = s_reg.mem[OFS_IF_CONFIG];
   assign i2c_addr = cfg_word[ADDR_LSB +: ADDR_W];
   assign clk_mode = cfg_word[CLK_MODE_LSB +: 2];

   // ----------------------------------------------------------------
   // spi link domain
   // ----------------------------------------------------------------
   // settings and resp_word are quasi-static while a frame runs
   spi_frame_link u_link (
      .sclk(spi_sclk),
      .ss(spi_ss),
      .mosi(spi_mosi),
      .miso(spi_miso_out),
      .rst_n(rst_n),
      .ss_active_high(cfg_word[SS_POL_BIT]),
      .latch_falling(clk_mode[1] ^ clk_mode[0]),
      .resp_word(resp_word),
      .frame_word(spi_frame),
      .frame_toggle(spi_frame_tgl),
      .selected(spi_selected)
   );

   // miso drives only in spi mode while selected
   assign spi_miso_oe_n = ~(spi_selected & ~s_reg.sel_sync[1]);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic scl_rise;
      logic scl_fall;
      logic start_c;
      logic stop_c;
      logic spi_mode;
      logic new_cmd;
      logic [FRAME_BITS-1:0] new_word;
      logic [7:0] c;
      logic [4:0] idx;
      logic [7:0] nb;
      scl_rise = 1'b0;
      scl_fall = 1'b0;
      start_c = 1'b0;
      stop_c = 1'b0;
      spi_mode = 1'b0;
      new_cmd = 1'b0;
      new_word = '0;
      c = 8'h00;
      idx = 5'h00;
      nb = 8'h00;
      s_next = s_reg;

      // synchronisers, first stage read only by the second
      s_next.sel_sync = {s_reg.sel_sync[0], if_sel};
      s_next.prod_sync = {s_reg.prod_sync[0], prod_test};
      s_next.scl_sync = {s_reg.scl_sync[1:0], i2c_scl};
      s_next.sda_sync = {s_reg.sda_sync[1:0], i2c_sda_in};
      s_next.frame_sync = {s_reg.frame_sync[1:0], spi_frame_tgl};
      spi_mode = ~s_reg.sel_sync[1];

      // spi frame event: toggle seen, word already stable
      if (spi_mode && (s_reg.frame_sync[2] != s_reg.frame_sync[1])) begin
         new_cmd = 1'b1;
         new_word = spi_frame;
      end

      // i2c line events from the synchronised copies
      scl_rise = s_reg.scl_sync[1] & ~s_reg.scl_sync[2];
      scl_fall = ~s_reg.scl_sync[1] & s_reg.scl_sync[2];
      start_c = s_reg.scl_sync[1] & s_reg.scl_sync[2] &
                s_reg.sda_sync[2] & ~s_reg.sda_sync[1];
      stop_c = s_reg.scl_sync[1] & s_reg.scl_sync[2] &
               ~s_reg.sda_sync[2] & s_reg.sda_sync[1];

      // i2c target; scl is never held low by this end
      if (spi_mode) begin
         s_next.i2c_st = I2C_IDLE;
         s_next.sda_low = 1'b0;
         s_next.hs_mode = 1'b0;
      end else if (start_c || stop_c) begin
         // a repeated start or stop closes a written frame
         if (s_reg.byte_cnt != 2'h0 &&
             (!s_reg.hs_mode || s_reg.byte_cnt == 2'(FRAME_BYTES))) begin
            new_cmd = 1'b1;
            new_word = s_reg.i2c_frame;
         end
         s_next.byte_cnt = 2'h0;
         s_next.i2c_frame = '0;
         s_next.bit_cnt = 4'h0;
         s_next.sda_low = 1'b0;
         s_next.i2c_st = start_c ? I2C_ADDR : I2C_IDLE;
         if (stop_c) begin
            s_next.hs_mode = 1'b0;
         end
      end else if (scl_rise) begin
         case (s_reg.i2c_st)
            I2C_ADDR, I2C_WRITE: begin
               s_next.shift = {s_reg.shift[6:0], s_reg.sda_sync[1]};
               s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
            end
            I2C_READ: begin
               s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
            end
            I2C_READ_ACK: begin
               s_next.ack_ok = ~s_reg.sda_sync[1];
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (s_reg.i2c_st)
            I2C_ADDR: begin
               if (s_reg.bit_cnt == 4'(BYTE_BITS)) begin
                  if (s_reg.shift[7:3] == HS_CODE_PREFIX) begin
                     // master code: not acknowledged, go high speed
                     s_next.hs_mode = 1'b1;
                     s_next.i2c_st = I2C_IDLE;
                  end else if (s_reg.shift[7:1] == i2c_addr) begin
                     s_next.rw = s_reg.shift[0];
                     s_next.sda_low = 1'b1;
                     s_next.i2c_st = I2C_ADDR_ACK;
                  end else begin
                     s_next.i2c_st = I2C_IDLE;
                  end
               end
            end
            I2C_ADDR_ACK: begin
               s_next.bit_cnt = 4'h0;
               if (s_reg.rw) begin
                  // reads always start with the live status byte
                  nb = resp_byte(2'h0, resp_word);
                  s_next.shift = nb;
                  s_next.sda_low = ~nb[7];
                  s_next.rd_idx = 2'h1;
                  s_next.i2c_st = I2C_READ;
               end else begin
                  s_next.sda_low = 1'b0;
                  s_next.i2c_st = I2C_WRITE;
               end
            end
            I2C_WRITE: begin
               if (s_reg.bit_cnt == 4'(BYTE_BITS)) begin
                  if (s_reg.byte_cnt != 2'(FRAME_BYTES)) begin
                     s_next.i2c_frame[(2 - s_reg.byte_cnt) * 8 +: 8] =
                        s_reg.shift;
                     s_next.byte_cnt = s_reg.byte_cnt + 2'h1;
                  end
                  s_next.sda_low = 1'b1;
                  s_next.i2c_st = I2C_WRITE_ACK;
               end
            end
            I2C_WRITE_ACK: begin
               s_next.sda_low = 1'b0;
               s_next.bit_cnt = 4'h0;
               s_next.i2c_st = I2C_WRITE;
            end
            I2C_READ: begin
               if (s_reg.bit_cnt == 4'(BYTE_BITS)) begin
                  s_next.sda_low = 1'b0;
                  s_next.i2c_st = I2C_READ_ACK;
               end else begin
                  s_next.shift = {s_reg.shift[6:0], 1'b0};
                  s_next.sda_low = ~s_reg.shift[6];
               end
            end
            I2C_READ_ACK: begin
               s_next.bit_cnt = 4'h0;
               if (s_reg.ack_ok) begin
                  nb = resp_byte(s_reg.rd_idx, resp_word);
                  s_next.shift = nb;
                  s_next.sda_low = ~nb[7];
                  if (s_reg.rd_idx != 2'h3) begin
                     s_next.rd_idx = s_reg.rd_idx + 2'h1;
                  end
                  s_next.i2c_st = I2C_READ;
               end else begin
                  s_next.i2c_st = I2C_IDLE;
               end
            end
            default: begin
               s_next.sda_low = 1'b0;
            end
         endcase
      end

      // command intake; frames that arrive while busy are dropped
      if (new_cmd && !s_reg.busy) begin
         c = new_word[23:16];
         s_next.cmd = new_word;
         s_next.busy = 1'b1;
         if (in_range(c, CMD_WR_LO, CMD_TRIM_HI) || c == CMD_PAGE_INC) begin
            s_next.exec_cnt = PROG_CYCLES;
         end else begin
            s_next.exec_cnt = READ_CYCLES;
         end
      end

      // execution completes when the countdown expires
      if (s_reg.busy) begin
         s_next.exec_cnt = s_reg.exec_cnt - 8'h01;
         if (s_reg.exec_cnt == 8'h01) begin
            s_next.busy = 1'b0;
            c = s_reg.cmd[23:16];
            if (in_range(c, CMD_WR_LO, CMD_WR_HI)) begin
               idx = 5'(c - CMD_WR_LO);
               // a word already written on this page stays as it is
               if (int'(idx) >= MEM_WORDS || s_reg.prog[idx]) begin
                  s_next.data_flag = 1'b1;
               end else begin
                  s_next.mem[idx] = s_reg.cmd[15:0];
                  s_next.prog[idx] = 1'b1;
                  s_next.data_flag = 1'b0;
               end
            end else if (in_range(c, CMD_TRIM_LO, CMD_TRIM_HI)) begin
               idx = 5'(c - CMD_TRIM_LO);
               if (s_reg.prod_sync[1] && int'(idx) < TRIM_WORDS) begin
                  s_next.trim[idx] = s_reg.cmd[15:0];
                  s_next.data_flag = 1'b0;
               end else begin
                  s_next.data_flag = 1'b1;
               end
            end else if (c == CMD_PAGE_INC) begin
               if (s_reg.page == PAGE_LAST) begin
                  s_next.data_flag = 1'b1;
               end else begin
                  // new page: every word reads unprogrammed again
                  s_next.page = s_reg.page + 2'h1;
                  s_next.prog = '0;
                  for (int i = 0; i < MEM_WORDS; i++) begin
                     s_next.mem[i] = WORD_RESET;
                  end
                  s_next.data_flag = 1'b0;
               end
            end else if (in_range(c, CMD_RD_LO, CMD_RD_HI)) begin
               idx = 5'(c - CMD_RD_LO);
               s_next.data = (int'(idx) < MEM_WORDS) ? s_reg.mem[idx] :
                             WORD_RESET;
               s_next.data_flag = ecc_corrected;
            end else if (in_range(c, CMD_MST_LO, CMD_MST_HI)) begin
               // undefined low bits are returned as zero
               s_next.data = WORD_RESET;
               s_next.data[MSW_CORR_BIT] = ecc_corrected;
               s_next.data[MSW_PAGE_LSB +: 2] = s_reg.page;
               s_next.data_flag = ecc_corrected;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0; // page starts at PAGE_RESET, words at WORD_RESET
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign i2c_sda_out = 1'b0;
   assign i2c_sda_oe_n = ~s_reg.sda_low;
   assign busy = s_reg.busy;
   assign page_count = s_reg.page;
   assign customer_id = {s_reg.mem[OFS_CUST_ID_HI],
                         s_reg.mem[OFS_CUST_ID_LO]};
   assign trim_bits = s_reg.trim;

endmodule : serial_cmd_port

// ### core/cmd_port_pkg.sv
// shared constants for the serial command port and its memory pages
package cmd_port_pkg;

   // ----------------------------------------------------------------
   // framing
   // ----------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int FRAME_BYTES = 3;
   localparam int FRAME_BITS = 24;
   localparam int BYTE_BITS = 8;

   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_RD_LO = 8'h20;
   localparam logic [7:0] CMD_RD_HI = 8'h37;
   localparam logic [7:0] CMD_WR_LO = 8'h40;
   localparam logic [7:0] CMD_WR_HI = 8'h57;
   localparam logic [7:0] CMD_TRIM_LO = 8'h58;
   localparam logic [7:0] CMD_TRIM_HI = 8'h5b;
   localparam logic [7:0] CMD_PAGE_INC = 8'h5e;
   localparam logic [7:0] CMD_MST_LO = 8'h80;
   localparam logic [7:0] CMD_MST_HI = 8'h8e;

   // ----------------------------------------------------------------
   // memory words, pages and reset values
   // ----------------------------------------------------------------
   localparam logic [4:0] OFS_CUST_ID_LO = 5'h00;
   localparam logic [4:0] OFS_CUST_ID_HI = 5'h01;
   localparam logic [4:0] OFS_IF_CONFIG = 5'h02;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [1:0] PAGE_RESET = 2'h0;
   localparam logic [1:0] PAGE_LAST = 2'h3;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ADDR_LSB = 0;
   localparam int ADDR_W = 7;
   localparam int SS_POL_BIT = 9;
   localparam int CLK_MODE_LSB = 10;
   localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
   localparam int ST_POWER = 6;
   localparam int ST_BUSY = 5;
   localparam int ST_MODE_LSB = 3;
   localparam int ST_MEM_ERR = 2;
   localparam int ST_DATA_FLAG = 1;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam int MSW_CORR_BIT = 15;
   localparam int MSW_PAGE_LSB = 13;

   // ----------------------------------------------------------------
   // execution times
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int READ_TIME_NS = 10;
   localparam int PROG_TIME_NS = 100;
   localparam logic [7:0] READ_CYCLES =
      8'((READ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] PROG_CYCLES =
      8'((PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

endpackage : cmd_port_pkg

// ### core/spi_frame_link.sv
// spi shift engine clocked by the link clock
module spi_frame_link
   import cmd_port_pkg::*;
(
   // link pins
   input wire logic sclk,
   input wire logic ss,
   input wire logic mosi,
   output logic miso,
   // reset and quasi-static settings
   input wire logic rst_n,
   input wire logic ss_active_high,
   input wire logic latch_falling,
   input wire logic [FRAME_BITS-1:0] resp_word,
   // captured frame toward the core clock
   output logic [FRAME_BITS-1:0] frame_word,
   output logic frame_toggle,
   output logic selected
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   // per-frame part, cleared whenever select goes inactive
   typedef struct packed {
      logic [4:0] cnt;
      logic [FRAME_BITS-1:0] rx;
      logic [FRAME_BITS-1:0] tx;
   } link_state_t;

   // persistent part, must survive select so the toggle is not undone
   typedef struct packed {
      logic [FRAME_BITS-1:0] word;
      logic tgl;
   } link_out_t;

   link_state_t l_reg, l_next;
   link_out_t o_reg, o_next;
   logic latch_clk;
   logic frame_rst_n;
   logic drive_reg;
   logic moved_reg;

   // select polarity and latch edge are static settings
   assign selected = (ss == ss_active_high);
   assign latch_clk = sclk ^ latch_falling;
   assign frame_rst_n = rst_n & selected;

   // first bit must stand before the first edge, so it comes from resp
   assign miso = (l_reg.cnt == 5'h00) ? resp_word[FRAME_BITS-1] :
                 moved_reg ? drive_reg : l_reg.tx[FRAME_BITS-1];
   assign frame_word = o_reg.word;
   assign frame_toggle = o_reg.tgl;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      l_next = l_reg;
      o_next = o_reg;
      if (l_reg.cnt != 5'(FRAME_BITS)) begin
         l_next.cnt = l_reg.cnt + 5'h01;
         l_next.rx = {l_reg.rx[FRAME_BITS-2:0], mosi};
         if (l_reg.cnt == 5'h00) begin
            l_next.tx = resp_word;
         end else begin
            l_next.tx = {l_reg.tx[FRAME_BITS-2:0], 1'b0};
         end
         // only a full three-byte frame is handed over
         if (l_reg.cnt == 5'(FRAME_BITS - 1)) begin
            o_next.word = {l_reg.rx[FRAME_BITS-2:0], mosi};
            o_next.tgl = ~o_reg.tgl;
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge latch_clk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         l_reg <= '0;
      end else begin
         l_reg <= l_next;
      end
   end

   // bits move on the output edge only, so the host gets half a period
   always_ff @(negedge latch_clk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         drive_reg <= 1'b0;
         moved_reg <= 1'b0;
      end else begin
         drive_reg <= (l_reg.cnt == 5'h00) ? resp_word[FRAME_BITS-1] :
                      l_reg.tx[FRAME_BITS-2];
         moved_reg <= 1'b1;
      end
   end

   // the toggle flop is reset only by the system reset
   always_ff @(posedge latch_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_reg <= '0;
      end else begin
         o_reg <= o_next;
      end
   end

endmodule : spi_frame_link

// ### dv/spi_host_model.sv
// host side spi master model, mode 00 with active low select
module spi_host_model (
   // link pins
   output logic sclk,
   output logic ss_n,
   output logic mosi,
   input wire logic miso,
   // one pulse per finished frame
   output logic done,
   output logic [23:0] rx
);
   timeunit 1ns;
   timeprecision 100ps;
   // link clock stands low between frames
   initial begin
      sclk = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b0;
      done = 1'b0;
      rx = 24'h0;
   end
   // whole three-byte frame, msb first, caller pads with zeros
   task automatic xfer(input logic [23:0] tx);
      ss_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         mosi = tx[i];
         #7.5 rx[i] = miso;
         sclk = 1'b1;
         #7.5 sclk = 1'b0;
      end
      #7.5 ss_n = 1'b1;
      mosi = ~mosi; // no stale level once released
      done = 1'b1;
      #1 done = 1'b0;
   endtask : xfer
endmodule : spi_host_model

// ### dv/serial_cmd_port_asserts.sv
// checker for the command port pins
module serial_cmd_port_asserts
   import cmd_port_pkg::*;
#(parameter int TRIM_WORDS = 4) (
   // watched pins
   input wire logic clk,
   input wire logic rst_n,
   input wire logic if_sel,
   input wire logic prod_test,
   input wire logic spi_miso_oe_n,
   input wire logic i2c_sda_out,
   input wire logic i2c_sda_oe_n,
   input wire logic busy,
   input wire logic [1:0] page_count,
   input wire logic [2*WORD_W-1:0] customer_id,
   input wire logic [TRIM_WORDS*WORD_W-1:0] trim_bits
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // page counter only climbs, one step at a time
   page_mono_a: assert property (page_count >= $past(page_count))
      else $error("page count fell");
   page_step_a: assert property ($changed(page_count) |->
      page_count == $past(page_count) + 2'h1) else $error("page jump");
   sda_drain_a: assert property (!i2c_sda_out)
      else $error("sda driven high");
   spi_off_a: assert property (if_sel [*4] |-> spi_miso_oe_n)
      else $error("miso on in i2c");
   i2c_off_a: assert property (!if_sel [*4] |-> i2c_sda_oe_n)
      else $error("sda on in spi");
   busy_span_a: assert property ($rose(busy) |->
      busy ##1 busy ##[1:19] !busy) else $error("busy length");
   id_busy_a: assert property ($changed(customer_id) |->
      busy || $past(busy)) else $error("id moved idle");
   // holds only while the strap stays low, as the bench keeps it
   trim_lock_a: assert property (!prod_test [*8] |=>
      $stable(trim_bits)) else $error("trim written");
   cover property ($rose(busy));
   cover property ($changed(page_count));
   cover property ($fell(if_sel));
endmodule : serial_cmd_port_asserts
bind serial_cmd_port serial_cmd_port_asserts #(.TRIM_WORDS(TRIM_WORDS))
   i_serial_cmd_port_asserts (.clk, .rst_n, .if_sel, .prod_test,
   .spi_miso_oe_n, .i2c_sda_out, .i2c_sda_oe_n, .busy, .page_count,
   .customer_id, .trim_bits);

// ### dv/serial_cmd_port_tb.sv
// self-checking bench for the command port over spi and i2c
module serial_cmd_port_tb import cmd_port_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst_n, if_sel, ecc, busy, done, sclk, ss_n, mosi, miso;
   logic [1:0] page_count;
   logic [31:0] customer_id;
   logic [63:0] trim_bits;
   logic [23:0] rx;
   logic [47:0] q[$];
   logic [47:0] n;
   logic [15:0] d0, d1;
   logic sda_oe_n, scl = 1'b1, sda = 1'b1;
   int seed = 32'h5734;
   int miscompares = 0;
   int n_tests = 0;
   serial_cmd_port i_serial_cmd_port (.clk, .rst_n, .if_sel,
      .prod_test(1'b0), .spi_sclk(sclk), .spi_ss(ss_n), .spi_mosi(mosi),
      .spi_miso_out(miso), .spi_miso_oe_n(), .i2c_scl(scl),
      .i2c_sda_in(sda & sda_oe_n), .i2c_sda_out(),
      .i2c_sda_oe_n(sda_oe_n),
      .ecc_corrected(ecc), .busy, .page_count, .customer_id, .trim_bits);
   spi_host_model i_spi_host_model (.sclk, .ss_n, .mosi, .miso, .done, .rx);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic report_and_stop;
      if (miscompares == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   // one byte and its ack slot
   task automatic i2c_byte(input logic [8:0] b);
      for (int i = 8; i >= 0; i--) begin
         scl <= 1'b0;
         repeat (4) @(posedge clk);
         sda <= b[i];
         repeat (4) @(posedge clk);
         scl <= 1'b1;
         repeat (6) @(posedge clk);
      end
      check(64'(sda_oe_n), 64'h0);
   endtask : i2c_byte
   // note the masked reply to this frame, then sit out the busy time
   task automatic run(input logic [23:0] tx, m, e);
      int k;
      if (m != 24'h0) q.push_back({m, e});
      i_spi_host_model.xfer(tx);
      repeat (8) @(posedge clk);
      for (k = 0; k < 60 && busy !== 1'b0; k++) @(posedge clk);
      if (k == 60) begin
         miscompares++;
         report_and_stop();
      end
   endtask : run
   // each finished frame is held against the oldest note, if one is waiting
   always @(posedge done) begin
      if (q.size() > 0) begin
         n = q.pop_front();
         check(64'(rx & n[47:24]), 64'(n[23:0]));
      end
   end
   initial begin
      rst_n = 1'b0;
      if_sel = 1'b0;
      ecc = 1'b0;
      d0 = 16'($random(seed));
      d1 = 16'($random(seed));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      check(64'(customer_id), 64'h0);
      run({CMD_WR_LO, d0}, 24'h0, 24'h0);
      check(64'(customer_id), 64'(d0));
      ecc <= 1'b1;
      run({CMD_RD_LO, 16'h0}, 24'hff0000, 24'h400000);
      run({CMD_MST_LO, 16'h0}, 24'hffffff, {8'h42, d0});
      run({CMD_WR_LO, d1}, 24'hffe000, 24'h428000);
      run({CMD_WR_HI - 8'h16, d1}, 24'hff0000, 24'h420000);
      check(64'(customer_id), 64'({d1, d0}));
      run({CMD_TRIM_LO, 16'hffff}, 24'hff0000, 24'h400000);
      check(trim_bits, 64'h0);
      n = {24'h200000, 24'h0};
      for (int p = 1; p < 5; p++) begin
         run({CMD_PAGE_INC, 16'h0}, n[47:24], n[23:0]);
         run({CMD_MST_LO, 16'h0}, 24'hff0000,
             p < 4 ? 24'h400000 : 24'h420000);
         n = {24'h006000, 24'((p < 3 ? p : 3) << 13)};
      end
      check(64'({page_count, customer_id}), 64'h300000000);
      q.push_back(n);
      i_spi_host_model.xfer({CMD_WR_LO, d1});
      run(24'h0, 24'h200000, 24'h200000);
      check(64'(customer_id), 64'(d1));
      // two-byte i2c write, low data byte left to the padding
      if_sel <= 1'b1;
      repeat (4) @(posedge clk);
      sda <= 1'b0;
      repeat (4) @(posedge clk);
      i2c_byte(9'h001);
      i2c_byte({CMD_WR_LO + 8'h01, 1'b1});
      i2c_byte(9'h14b);
      scl <= 1'b0;
      sda <= 1'b0;
      repeat (4) @(posedge clk);
      scl <= 1'b1;
      repeat (4) @(posedge clk);
      sda <= 1'b1;
      repeat (40) @(posedge clk);
      check(64'(customer_id), 64'({16'ha500, d1}));
      if_sel <= 1'b0;
      repeat (6) @(posedge clk);
      report_and_stop();
   end
endmodule : serial_cmd_port_tb
